// ===== verilog/crossbar_pkg.sv
`default_nettype none
package crossbar_pkg;
	// Port counts and path widths
	localparam int NUM_M = 3;
	localparam int NUM_S = 3;
	localparam int NUM_X = 2;
	localparam int AW = 32;
	localparam int DW = 32;
	localparam int ID_W = 2;
	localparam int PRIO_W = 2;
	// Master identifiers
	localparam logic [ID_W-1:0] M_IFETCH = 2'h0;
	localparam logic [ID_W-1:0] M_DATA = 2'h1;
	localparam logic [ID_W-1:0] M_DMA = 2'h2;
	// Slave indices; external slaves start after the flash
	localparam int S_FLASH = 0;
	localparam int S_SRAM = 1;
	localparam int S_PERIPH = 2;
	localparam int X_FIRST = 1;
	// Address map, decoded on the top two address bits
	localparam int REGION_HI = 31;
	localparam int REGION_LO = 30;
	localparam logic [1:0] REGION_FLASH = 2'h0;
	localparam logic [1:0] REGION_SRAM = 2'h1;
	// Fixed priority per master, index 0 is instruction fetch
	localparam logic [NUM_M-1:0][PRIO_W-1:0] PRIO_FIXED = {2'h0, 2'h1, 2'h1};
	localparam logic [PRIO_W-1:0] PRIO_BOOST = 2'h3;
	// Flash line geometry
	localparam int LINE_W = 128;
	localparam int NUM_BUF = 4;
	localparam int BUF_W = 2;
	localparam int LINE_LSB = 4;
	localparam int WORD_LSB = 2;
	localparam int WSEL_W = 2;
	localparam int TAG_W = AW - LINE_LSB;
endpackage : crossbar_pkg
`default_nettype wire

// ===== verilog/flash_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_port_if;
	import crossbar_pkg::*;
	logic req; // Request held until ready
	logic we; // Write request
	logic [AW-1:0] addr; // Byte address
	logic [DW-1:0] wdata; // Write data
	logic [DW-1:0] rdata; // Read data
	logic ready; // Transfer completes this cycle
	modport ctrl (output req, we, addr, wdata, input rdata, ready);
	modport mem (input req, we, addr, wdata, output rdata, ready);
endinterface : flash_port_if
`default_nettype wire

// ===== verilog/flash_prefetch_slave.sv
`timescale 1ns/1ps
`default_nettype none
module flash_prefetch_slave (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Bus side
	flash_port_if.mem bus,
	// Nonvolatile array side
	output logic o_nv_rd,
	output logic [crossbar_pkg::TAG_W-1:0] o_nv_addr,
	input wire logic [crossbar_pkg::LINE_W-1:0] i_nv_rdata
);
	import crossbar_pkg::*;

	typedef enum logic [1:0] {FL_IDLE, FL_FETCH, FL_RESP} fl_state_type;

	////////////////////////////////////////////////////////////////////////
	// Word picked out of a line by the address
	function automatic logic [DW-1:0] word_of(input logic [LINE_W-1:0] line,
		input logic [AW-1:0] a);
		logic [WSEL_W-1:0] sel;
		sel = a[LINE_LSB-1:WORD_LSB];
		return line[sel*DW +: DW];
	endfunction : word_of

	fl_state_type state_reg; // Miss sequencer
	logic [NUM_BUF-1:0][LINE_W-1:0] line_reg; // Prefetch lines
	logic [NUM_BUF-1:0][TAG_W-1:0] tag_reg; // Line addresses
	logic [NUM_BUF-1:0] valid_reg; // Line holds data
	logic [BUF_W-1:0] fill_reg; // Next line to replace
	logic [TAG_W-1:0] miss_tag_reg; // Line being fetched
	logic [DW-1:0] resp_reg; // Registered miss data
	logic hit; // Address found in a line
	logic [DW-1:0] hit_word; // Word from the hit line
	logic rd_req; // Read request on the bus

	////////////////////////////////////////////////////////////////////////
	// Buffer lookup
	always_comb begin
		hit = 1'b0;
		hit_word = '0;
		for (int b = 0; b < NUM_BUF; b++) begin
			if (valid_reg[b] && tag_reg[b] == bus.addr[AW-1:LINE_LSB]) begin
				hit = 1'b1;
				hit_word = word_of(line_reg[b], bus.addr);
			end
		end
	end

	assign rd_req = bus.req && !bus.we;
	assign o_nv_rd = (state_reg == FL_FETCH);
	assign o_nv_addr = miss_tag_reg;
	assign bus.ready = (bus.req && bus.we)
		|| (rd_req && state_reg == FL_IDLE && hit)
		|| (state_reg == FL_RESP);
	assign bus.rdata = (state_reg == FL_RESP) ? resp_reg : hit_word;

	////////////////////////////////////////////////////////////////////////
	// registered miss path
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= FL_IDLE;
			miss_tag_reg <= '0;
			resp_reg <= '0;
		end else begin
			case (state_reg)
				// Misses start a line fetch
				FL_IDLE: begin
					if (rd_req && !hit) begin
						miss_tag_reg <= bus.addr[AW-1:LINE_LSB];
						state_reg <= FL_FETCH;
					end
				end
				// Array data captured at the end of the read
				FL_FETCH: begin
					resp_reg <= word_of(i_nv_rdata, bus.addr);
					state_reg <= FL_RESP;
				end
				default: begin
					state_reg <= FL_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// prefetch line fill
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			line_reg <= '0;
			tag_reg <= '0;
			valid_reg <= '0;
			fill_reg <= '0;
		end else if (state_reg == FL_FETCH) begin
			line_reg[fill_reg] <= i_nv_rdata;
			tag_reg[fill_reg] <= miss_tag_reg;
			valid_reg[fill_reg] <= 1'b1;
			fill_reg <= fill_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_miss_start;
		rd_req && state_reg == FL_IDLE && !hit;
	endsequence
	sequence s_two_waits;
		!bus.ready ##1 !bus.ready ##1 bus.ready;
	endsequence

	a_hit_zero_wait: assert property (
		rd_req && state_reg == FL_IDLE && hit |-> bus.ready)
		else $error("flash hit did not answer at once");
	a_miss_two_waits: assert property (
		s_miss_start |-> s_two_waits)
		else $error("flash miss did not take two wait states");
	a_line_to_word: assert property (
		o_nv_rd |=> bus.ready && bus.rdata == word_of($past(i_nv_rdata),
			bus.addr))
		else $error("flash word not taken from fetched line");
endmodule : flash_prefetch_slave
`default_nettype wire

// ===== verilog/crossbar_switch.sv
// Functional notes
// - three masters, three slaves, parallel pairs
// - 32-bit address and data paths
// - two in flight, second is flash fetch
// - contended slave goes to higher priority
// - losers stall until winner finishes
// - equal priority rotates after last grant
// - fixed priority per master by default
// - per-master boost raises priority temporarily
// - fetch, data, DMA masters; flash, SRAM, bridge
// - flash 32-bit bus over 128-bit lines
// - four 128-bit prefetch lines, zero wait
// - flash miss costs two wait states
`timescale 1ns/1ps
`default_nettype none
module crossbar_switch (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Master ports: fetch, load/store data, DMA
	input wire logic [crossbar_pkg::NUM_M-1:0] i_m_req,
	input wire logic [crossbar_pkg::NUM_M-1:0] i_m_we,
	input wire logic [crossbar_pkg::NUM_M-1:0] i_m_lock,
	input wire logic [crossbar_pkg::NUM_M-1:0] i_m_boost,
	input wire logic [crossbar_pkg::NUM_M-1:0][crossbar_pkg::AW-1:0] i_m_addr,
	input wire logic [crossbar_pkg::NUM_M-1:0][crossbar_pkg::DW-1:0] i_m_wdata,
	output logic [crossbar_pkg::NUM_M-1:0] o_m_ready,
	output logic [crossbar_pkg::NUM_M-1:0][crossbar_pkg::DW-1:0] o_m_rdata,
	// External slaves: SRAM then peripheral bridge
	output logic [crossbar_pkg::NUM_X-1:0] o_x_req,
	output logic [crossbar_pkg::NUM_X-1:0] o_x_we,
	output logic [crossbar_pkg::NUM_X-1:0][crossbar_pkg::AW-1:0] o_x_addr,
	output logic [crossbar_pkg::NUM_X-1:0][crossbar_pkg::DW-1:0] o_x_wdata,
	input wire logic [crossbar_pkg::NUM_X-1:0] i_x_ready,
	input wire logic [crossbar_pkg::NUM_X-1:0][crossbar_pkg::DW-1:0] i_x_rdata,
	// Nonvolatile array
	output logic o_nv_rd,
	output logic [crossbar_pkg::TAG_W-1:0] o_nv_addr,
	input wire logic [crossbar_pkg::LINE_W-1:0] i_nv_rdata
);
	import crossbar_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [ID_W-1:0] slave_of(input logic [AW-1:0] a);
		if (a[REGION_HI:REGION_LO] == REGION_FLASH) begin
			return ID_W'(S_FLASH);
		end else if (a[REGION_HI:REGION_LO] == REGION_SRAM) begin
			return ID_W'(S_SRAM);
		end else begin
			return ID_W'(S_PERIPH);
		end
	endfunction : slave_of

	// Next master identifier in rotation
	function automatic logic [ID_W-1:0] next_id(input logic [ID_W-1:0] id);
		return (id == ID_W'(NUM_M - 1)) ? '0 : id + 1'b1;
	endfunction : next_id

	function automatic logic [ID_W-1:0] pick(input logic [NUM_M-1:0] mask,
		input logic [NUM_M-1:0][PRIO_W-1:0] prio,
		input logic [ID_W-1:0] last);
		logic [PRIO_W-1:0] best;
		logic [ID_W-1:0] idx;
		logic found;
		best = '0;
		idx = last;
		found = 1'b0;
		for (int m = 0; m < NUM_M; m++) begin
			if (mask[m] && prio[m] > best) begin
				best = prio[m];
			end
		end
		pick = last;
		for (int k = 0; k < NUM_M; k++) begin
			idx = next_id(idx);
			if (!found && mask[idx] && prio[idx] == best) begin
				pick = idx;
				found = 1'b1;
			end
		end
	endfunction : pick

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [NUM_S-1:0] own_valid_reg; // Slave has an owner
	logic [NUM_S-1:0][ID_W-1:0] own_id_reg; // Owning master
	logic [NUM_S-1:0][ID_W-1:0] last_reg; // Last master granted
	logic [NUM_M-1:0][ID_W-1:0] tgt; // Decoded slave per master
	logic [NUM_M-1:0][PRIO_W-1:0] eff_prio; // Priority in force
	logic [NUM_M-1:0] owns_any; // Master already holds a slave
	logic [NUM_S-1:0][NUM_M-1:0] want; // Requests per slave
	logic [NUM_S-1:0] grant_v; // New grant this cycle
	logic [NUM_S-1:0][ID_W-1:0] grant_id; // Master of new grant
	logic [NUM_S-1:0] release_s; // Owner finished
	logic [NUM_S-1:0] s_req; // Routed request
	logic [NUM_S-1:0] s_we;
	logic [NUM_S-1:0][AW-1:0] s_addr;
	logic [NUM_S-1:0][DW-1:0] s_wdata;
	logic [NUM_S-1:0] s_ready;
	logic [NUM_S-1:0][DW-1:0] s_rdata;
	logic gen_busy; // General slot taken
	logic gen_taken; // General slot claimed in arbitration
	logic is_fetch; // Candidate is fetch to flash
	flash_port_if fbus ();

	////////////////////////////////////////////////////////////////////////
	// Request decode and priority
	always_comb begin
		owns_any = '0;
		want = '0;
		for (int m = 0; m < NUM_M; m++) begin
			tgt[m] = slave_of(i_m_addr[m]);
			eff_prio[m] = i_m_boost[m] ? PRIO_BOOST : PRIO_FIXED[m];
		end
		for (int s = 0; s < NUM_S; s++) begin
			if (own_valid_reg[s]) begin
				owns_any[own_id_reg[s]] = 1'b1;
			end
		end
		for (int s = 0; s < NUM_S; s++) begin
			for (int m = 0; m < NUM_M; m++) begin
				want[s][m] = i_m_req[m] && tgt[m] == ID_W'(s) && !owns_any[m];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Arbitration per slave
	always_comb begin
		gen_busy = 1'b0;
		grant_v = '0;
		grant_id = '0;
		is_fetch = 1'b0;
		for (int s = 0; s < NUM_S; s++) begin
			if (own_valid_reg[s] && !(s == S_FLASH && own_id_reg[s] == M_IFETCH))
			begin
				gen_busy = 1'b1;
			end
		end
		gen_taken = gen_busy;
		for (int s = 0; s < NUM_S; s++) begin
			if (!own_valid_reg[s] && want[s] != '0) begin
				grant_id[s] = pick(want[s], eff_prio, last_reg[s]);
				is_fetch = (s == S_FLASH) && grant_id[s] == M_IFETCH;
				// one general slot plus flash fetch
				if (is_fetch || !gen_taken) begin
					grant_v[s] = 1'b1;
					gen_taken = gen_taken || !is_fetch;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ownership held through burst
	always_comb begin
		for (int s = 0; s < NUM_S; s++) begin
			release_s[s] = own_valid_reg[s] && !i_m_lock[own_id_reg[s]]
				&& (s_ready[s] || !i_m_req[own_id_reg[s]]);
		end
	end

	// Ownership and rotation state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			own_valid_reg <= '0;
			own_id_reg <= '0;
			last_reg <= '0;
		end else begin
			for (int s = 0; s < NUM_S; s++) begin
				if (grant_v[s]) begin
					own_valid_reg[s] <= 1'b1;
					own_id_reg[s] <= grant_id[s];
					last_reg[s] <= grant_id[s];
				end else if (release_s[s]) begin
					own_valid_reg[s] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// routing of owned pairs
	always_comb begin
		o_m_ready = '0;
		o_m_rdata = '0;
		for (int s = 0; s < NUM_S; s++) begin
			s_req[s] = own_valid_reg[s] && i_m_req[own_id_reg[s]]
				&& tgt[own_id_reg[s]] == ID_W'(s);
			s_we[s] = i_m_we[own_id_reg[s]];
			s_addr[s] = i_m_addr[own_id_reg[s]];
			s_wdata[s] = i_m_wdata[own_id_reg[s]];
			if (s_req[s] && s_ready[s]) begin
				o_m_ready[own_id_reg[s]] = 1'b1;
				o_m_rdata[own_id_reg[s]] = s_rdata[s];
			end
		end
	end

	// Slave answers; flash joins here so one process drives them
	always_comb begin
		s_ready[S_FLASH] = fbus.ready;
		s_rdata[S_FLASH] = fbus.rdata;
		for (int x = 0; x < NUM_X; x++) begin
			o_x_req[x] = s_req[x + X_FIRST];
			o_x_we[x] = s_we[x + X_FIRST];
			o_x_addr[x] = s_addr[x + X_FIRST];
			o_x_wdata[x] = s_wdata[x + X_FIRST];
			s_ready[x + X_FIRST] = i_x_ready[x];
			s_rdata[x + X_FIRST] = i_x_rdata[x];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flash slave with prefetch lines
	assign fbus.req = s_req[S_FLASH];
	assign fbus.we = s_we[S_FLASH];
	assign fbus.addr = s_addr[S_FLASH];
	assign fbus.wdata = s_wdata[S_FLASH];

	flash_prefetch_slave u_flash (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.bus(fbus.mem),
		.o_nv_rd(o_nv_rd),
		.o_nv_addr(o_nv_addr),
		.i_nv_rdata(i_nv_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	logic [1:0] n_active; // Owned slave count
	logic higher_lost; // Granted master had a stronger rival
	always_comb begin
		n_active = '0;
		higher_lost = 1'b0;
		for (int s = 0; s < NUM_S; s++) begin
			n_active = n_active + 2'(own_valid_reg[s]);
			for (int m = 0; m < NUM_M; m++) begin
				if (grant_v[s] && want[s][m]
					&& eff_prio[m] > eff_prio[grant_id[s]]) begin
					higher_lost = 1'b1;
				end
			end
		end
	end

	a_two_in_flight: assert property (
		n_active <= 2'h2 && (n_active < 2'h2 || (own_valid_reg[S_FLASH]
			&& own_id_reg[S_FLASH] == M_IFETCH)))
		else $error("more than one general transaction in flight");
	a_high_prio_wins: assert property (
		!higher_lost)
		else $error("grant went past a higher priority requester");
	a_loser_stalls: assert property (
		(o_m_ready & ~owns_any) == '0)
		else $error("master without ownership saw ready");
	a_rr_rotation: assert property (
		grant_v[S_SRAM] && want[S_SRAM][M_IFETCH] && want[S_SRAM][M_DATA]
		&& i_m_boost == '0 && last_reg[S_SRAM] == M_IFETCH
		|-> grant_id[S_SRAM] == M_DATA)
		else $error("equal priority did not rotate");
	a_fixed_order: assert property (
		grant_v[S_PERIPH] && want[S_PERIPH][M_DMA] && want[S_PERIPH][M_DATA]
		&& i_m_boost == '0 |-> grant_id[S_PERIPH] != M_DMA)
		else $error("lower fixed priority won");
	a_boost_wins: assert property (
		grant_v[S_SRAM] && want[S_SRAM][M_DMA] && i_m_boost == 3'h4
		|-> grant_id[S_SRAM] == M_DMA)
		else $error("boosted master did not win");
	a_grant_held: assert property (
		own_valid_reg[S_SRAM] && i_m_lock[own_id_reg[S_SRAM]]
		|=> own_valid_reg[S_SRAM] && $stable(own_id_reg[S_SRAM]))
		else $error("locked grant was lost");
	a_addr_routed: assert property (
		o_x_req[0] |-> o_x_addr[0] == i_m_addr[own_id_reg[S_SRAM]]
		&& o_x_wdata[0] == i_m_wdata[own_id_reg[S_SRAM]])
		else $error("sram path not carried from owner");
	a_parallel_pairs: assert property (
		grant_v[S_FLASH] && grant_id[S_FLASH] == M_IFETCH
		&& want[S_SRAM] != '0 && !gen_busy |-> grant_v[S_SRAM])
		else $error("fetch blocked a parallel pair");
endmodule : crossbar_switch
`default_nettype wire

// ===== dv/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
	// Clock, reset and answer delay
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_lat,
	// External slaves
	input wire logic [crossbar_pkg::NUM_X-1:0] i_req,
	input wire logic [crossbar_pkg::NUM_X-1:0] i_we,
	input wire logic [crossbar_pkg::NUM_X-1:0][crossbar_pkg::AW-1:0] i_addr,
	input wire logic [crossbar_pkg::NUM_X-1:0][crossbar_pkg::DW-1:0] i_wdata,
	output logic [crossbar_pkg::NUM_X-1:0] o_ready,
	output logic [crossbar_pkg::NUM_X-1:0][crossbar_pkg::DW-1:0] o_rdata,
	// Array
	input wire logic i_nv_rd,
	input wire logic [crossbar_pkg::TAG_W-1:0] i_nv_addr,
	output logic [crossbar_pkg::LINE_W-1:0] o_nv_rdata
);
	import crossbar_pkg::*;
	logic [NUM_X-1:0][3:0] wait_reg; // Cycles spent on the current beat
	logic [NUM_X-1:0][DW-1:0] store_reg; // Last word written per slave
	////////////////////////////////////////////////////////////////////////
	// Beat timing and write capture
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_reg <= '0;
			store_reg <= '0;
		end else begin
			for (int s = 0; s < NUM_X; s++) begin
				// Restart the count once a beat ends
				if (!i_req[s] || o_ready[s]) begin
					wait_reg[s] <= 4'h0;
				end else begin
					wait_reg[s] <= wait_reg[s] + 4'h1;
				end
				if (o_ready[s] && i_we[s]) begin
					store_reg[s] <= i_wdata[s];
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Answers; data is inverted outside its valid cycle
	always_comb begin
		for (int s = 0; s < NUM_X; s++) begin
			o_ready[s] = i_req[s] && (wait_reg[s] == i_lat);
			o_rdata[s] = i_addr[s] ^ store_reg[s];
			if (!o_ready[s]) begin
				o_rdata[s] = ~o_rdata[s];
			end
		end
		// Each word holds its own byte address
		for (int w = 0; w < 4; w++) begin
			o_nv_rdata[w*32 +: 32] = {i_nv_addr, 2'(w), 2'h0};
		end
		if (!i_nv_rd) begin
			o_nv_rdata = ~o_nv_rdata;
		end
	end
endmodule : far_side_model
`default_nettype wire

// ===== dv/three_port_crossbar_arbiter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module three_port_crossbar_arbiter_bench;
	import crossbar_pkg::*;
	// Clock, reset and bench counters
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	logic [3:0] lat = 4'h2;
	// Master side stimulus
	logic [NUM_M-1:0] m_req = '0;
	logic [NUM_M-1:0] m_we = '0;
	logic [NUM_M-1:0] m_lock = '0;
	logic [NUM_M-1:0] m_boost = '0;
	logic [NUM_M-1:0][AW-1:0] m_addr = '0;
	logic [NUM_M-1:0][DW-1:0] m_wdata = '0;
	logic [NUM_M-1:0] m_ready;
	logic [NUM_M-1:0][DW-1:0] m_rdata;
	// Far side wires
	logic [NUM_X-1:0] x_req, x_we, x_ready;
	logic [NUM_X-1:0][AW-1:0] x_addr;
	logic [NUM_X-1:0][DW-1:0] x_wdata, x_rdata;
	logic nv_rd;
	logic [TAG_W-1:0] nv_addr;
	logic [LINE_W-1:0] nv_rdata;
	always #50 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	crossbar_switch dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_m_req(m_req),
		.i_m_we(m_we), .i_m_lock(m_lock), .i_m_boost(m_boost),
		.i_m_addr(m_addr), .i_m_wdata(m_wdata), .o_m_ready(m_ready),
		.o_m_rdata(m_rdata), .o_x_req(x_req), .o_x_we(x_we),
		.o_x_addr(x_addr), .o_x_wdata(x_wdata), .i_x_ready(x_ready),
		.i_x_rdata(x_rdata), .o_nv_rd(nv_rd), .o_nv_addr(nv_addr),
		.i_nv_rdata(nv_rdata));
	far_side_model far_u (.i_clk(clk), .i_rst_n(rst_n), .i_lat(lat),
		.i_req(x_req), .i_we(x_we), .i_addr(x_addr), .i_wdata(x_wdata),
		.o_ready(x_ready), .o_rdata(x_rdata), .i_nv_rd(nv_rd),
		.i_nv_addr(nv_addr), .o_nv_rdata(nv_rdata));
	////////////////////////////////////////////////////////////////////////
	// Comparisons and verdict
	task automatic chk(input string nm, input logic [DW-1:0] e,
		input logic [DW-1:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_n(input string nm, input int e, input int g);
		chk(nm, 32'(e), 32'(g));
	endtask : chk_n
	task automatic complete_run();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////
	// One beat: hold until ready, drop one cycle later; n counts cycles
	task automatic xfer(input int m, input logic we, input logic [AW-1:0] a,
		input logic lk, input logic bst, output int n,
		output logic [DW-1:0] rd);
		@(negedge clk);
		m_we[m] = we;
		m_addr[m] = a;
		m_wdata[m] = ~a;
		m_lock[m] = lk;
		m_boost[m] = bst;
		m_req[m] = 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (m_ready[m] !== 1'b1 && n < 60);
		rd = m_rdata[m];
		@(negedge clk);
		m_req[m] = 1'b0;
		m_boost[m] = 1'b0;
	endtask : xfer
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		chk("ready_in_reset", 32'h0, 32'(m_ready));
		chk("xreq_in_reset", 32'h0, 32'(x_req));
		chk("nvrd_in_reset", 32'h0, 32'(nv_rd));
		rst_n = 1'b1;
	endtask : do_reset
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_flash();
		int n;
		logic [DW-1:0] rd, a;
		for (int i = 0; i < 8; i++) begin
			// Four fills, then each line again at word 0, 1, 2 and 3 in turn
			a = 32'h100 + 32'((i % 4) * 16) + 32'((i / 4) * (i % 4) * 4);
			xfer(0, 1'b0, a, 1'b0, 1'b0, n, rd);
			chk_n("flash_wait", (i < 4) ? 3 : 1, n);
			chk("flash_word", a & 32'hffff_fffc, rd);
		end
		// Fifth line evicts the oldest, which then misses
		xfer(0, 1'b0, 32'h140, 1'b0, 1'b0, n, rd);
		xfer(0, 1'b0, 32'h108, 1'b0, 1'b0, n, rd);
		chk_n("evict_wait", 3, n);
		xfer(1, 1'b1, 32'h200, 1'b0, 1'b0, n, rd);
		chk_n("flash_wr_wait", 1, n);
	endtask : t_flash
	task automatic t_ext();
		int n;
		logic [DW-1:0] rd, a;
		for (int i = 0; i < 4; i++) begin
			lat = (i < 2) ? 4'h0 : 4'h3;
			a = (i % 2 == 0) ? 32'h4000_0010 : 32'h8000_0020;
			xfer(2, 1'b1, a, 1'b0, 1'b0, n, rd);
			chk_n("ext_wr_wait", 1 + int'(lat), n);
			xfer(1, 1'b0, a + 32'h4, 1'b0, 1'b0, n, rd);
			chk("ext_rd_data", (a + 32'h4) ^ ~a, rd);
		end
	endtask : t_ext
	task automatic t_pair(input int ma, input logic [AW-1:0] aa,
		input int mb, input logic [AW-1:0] ab, input logic bb,
		output int na, output int nb);
		logic [DW-1:0] r1, r2;
		fork
			xfer(ma, 1'b0, aa, 1'b0, 1'b0, na, r1);
			xfer(mb, 1'b0, ab, 1'b0, bb, nb, r2);
		join
	endtask : t_pair
	task automatic t_arb();
		int na, nb;
		logic [DW-1:0] rd;
		lat = 4'h2;
		t_pair(0, 32'h300, 1, 32'h4000_0000, 1'b0, na, nb);
		chk_n("flash_beside", 3, na);
		chk_n("sram_beside", 3, nb);
		t_pair(1, 32'h4000_0000, 2, 32'h8000_0000, 1'b0, na, nb);
		chk_n("second_general", 1, int'(nb > na));
		t_pair(1, 32'h4000_0000, 2, 32'h4000_0008, 1'b0, na, nb);
		chk_n("fixed_winner", 3, na);
		chk_n("loser_stalls", 1, int'(nb > na));
		t_pair(1, 32'h4000_0000, 2, 32'h4000_0008, 1'b1, na, nb);
		chk_n("boost_winner", 3, nb);
		t_pair(1, 32'h8000_0000, 2, 32'h8000_0004, 1'b0, na, nb);
		chk_n("bridge_fixed", 3, na);
		t_pair(0, 32'h4000_0000, 1, 32'h4000_0008, 1'b0, na, nb);
		chk_n("tie_after_data", 3, na);
		// Lone fetch grant leaves fetch as the last owner
		xfer(0, 1'b0, 32'h4000_0004, 1'b0, 1'b0, na, rd);
		t_pair(0, 32'h4000_0000, 1, 32'h4000_0008, 1'b0, na, nb);
		chk_n("tie_after_fetch", 3, nb);
	endtask : t_arb
	task automatic t_lock();
		int n1, n2, t2, td;
		logic [DW-1:0] rd;
		fork
			begin
				xfer(1, 1'b0, 32'h4000_0000, 1'b1, 1'b0, n1, rd);
				xfer(1, 1'b0, 32'h4000_0004, 1'b0, 1'b0, n1, rd);
				t2 = cyc;
			end
			begin
				@(negedge clk);
				xfer(2, 1'b0, 32'h4000_0008, 1'b0, 1'b1, n2, rd);
				td = cyc;
			end
		join
		chk_n("burst_kept", 1, int'(td > t2));
	endtask : t_lock
	task automatic t_rereset();
		int n;
		logic [DW-1:0] rd;
		do_reset();
		xfer(0, 1'b0, 32'h120, 1'b0, 1'b0, n, rd);
		chk_n("lines_cleared", 3, n);
	endtask : t_rereset
	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		do_reset();
		t_flash();
		t_ext();
		t_arb();
		t_lock();
		t_rereset();
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		complete_run();
	end
endmodule : three_port_crossbar_arbiter_bench
`default_nettype wire
